// ---- hw/lcs_cell.sv ----
// Storage stage of one logic unit: eight latch/flip-flops, a ninth flip-flop and config port.
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns

module lcs_cell (
	// Clock, reset and freeze.
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic run_en_i,
	// Configuration port.
	input wire logic [7:0] cfg_addr_i,
	input wire logic [lcs_pkg::DATA_W-1:0] cfg_wdata_i,
	input wire logic cfg_wr_i,
	input wire logic cfg_rd_i,
	output logic [lcs_pkg::DATA_W-1:0] cfg_rdata_o,
	// Pins from outside the clock domain.
	input wire logic cell_clk_i,
	input wire logic global_set_reset_n_i,
	// Data from the lookup logic and carry chain.
	input wire logic [7:0] lut_i,
	input wire logic [7:0] din_i,
	input wire logic carry_input_i,
	input wire logic carry_out_i,
	// Routing control inputs.
	input wire logic cell_clk_enable_i,
	input wire logic alternate_clk_enable_i,
	input wire logic local_set_reset_i,
	input wire logic data_sel_i,
	// Element outputs.
	output logic [lcs_pkg::NUM_ELEM-1:0] q_o
);

	typedef struct packed {
		logic [lcs_pkg::CTRL_W-1:0] ctrl;
		logic [lcs_pkg::SRC_W-1:0] src;
		logic [lcs_pkg::NUM_ELEM-1:0] srval;
		logic [lcs_pkg::GRP_W-1:0] grp;
		logic clk_act_prev;
		logic [lcs_pkg::DATA_W-1:0] rdata;
	} lcs_cell_state_t;

	lcs_cell_state_t r;
	lcs_cell_state_t r_nxt;

	logic [1:0] pins_s;
	logic clk_act;
	logic clk_edge;
	logic gsr_eff;
	logic ce_raw;
	logic loc_sr_raw;
	logic sel_eff;
	logic [lcs_pkg::NUM_GRP-1:0] ce_g;
	logic [lcs_pkg::NUM_GRP-1:0] loc_sr_g;
	logic [lcs_pkg::NUM_ELEM-1:0] d_sel;
	logic ff_mode;
	logic loc_sr_async;
	logic loc_sr_over_ce;

	// Both pins cross into the clock domain before anything looks at them.
	lcs_sync #(
		.WIDTH(2),
		.RST_VAL(2'h2)
	) u_pin_sync (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.en_i(run_en_i),
		.d_i({global_set_reset_n_i, cell_clk_i}),
		.q_o(pins_s)
	);

	// Cell clock polarity and edge; the edge lags the pin by the synchroniser depth.
	assign clk_act = pins_s[0] ^ r.ctrl[lcs_pkg::CTRL_CLK_INV];
	assign clk_edge = clk_act && !r.clk_act_prev;

	// Global set/reset is active low and may be disabled per cell.
	assign gsr_eff = !pins_s[1] && r.ctrl[lcs_pkg::CTRL_GSR_EN];

	// Cell-wide mode bits.
	assign ff_mode = r.ctrl[lcs_pkg::CTRL_FF_MODE];
	assign loc_sr_async = r.ctrl[lcs_pkg::CTRL_LOC_SR_ASYNC];
	assign loc_sr_over_ce = r.ctrl[lcs_pkg::CTRL_LOC_SR_OVER_CE];

	// Control inputs with their optional inversions.
	assign ce_raw = cell_clk_enable_i ^ r.ctrl[lcs_pkg::CTRL_CE_INV];
	assign loc_sr_raw = local_set_reset_i ^ r.ctrl[lcs_pkg::CTRL_LOC_SR_INV];
	assign sel_eff = data_sel_i ^ r.ctrl[lcs_pkg::CTRL_SEL_INV];

	// Per group enable source and local set/reset use. The inversion also covers
	// the alternate enable, since both share one enable path.
	always_comb begin
		for (int g = 0; g < lcs_pkg::NUM_GRP; g++) begin
			unique case (r.grp[2*g +: 2])
				lcs_pkg::CE_PRIMARY: ce_g[g] = ce_raw;
				lcs_pkg::CE_ALTERNATE: ce_g[g] = alternate_clk_enable_i ^
					r.ctrl[lcs_pkg::CTRL_CE_INV];
				default: ce_g[g] = 1'b1;
			endcase
			loc_sr_g[g] = loc_sr_raw && r.grp[lcs_pkg::GRP_LOC_SR_USE + g];
		end
	end

	// Data source per element; front-end mode hands the choice to the select input.
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (r.ctrl[lcs_pkg::CTRL_FE_MODE]) begin
				d_sel[i] = sel_eff ? din_i[i] : lut_i[i];
			end else begin
				unique case (r.src[lcs_pkg::SRC_FIELD_W*i +: lcs_pkg::SRC_FIELD_W])
					lcs_pkg::SRC_ONE: d_sel[i] = 1'b1;
					lcs_pkg::SRC_LUT: d_sel[i] = lut_i[i];
					lcs_pkg::SRC_DIN: d_sel[i] = din_i[i];
					default: d_sel[i] = 1'b0;
				endcase
			end
		end
		// The ninth flop has its own short list and never sees the select.
		unique case (r.src[lcs_pkg::SRC_W-1 -: lcs_pkg::SRC_FIELD_W])
			lcs_pkg::SRC_ONE: d_sel[8] = 1'b1;
			lcs_pkg::SRC8_CARRY_IN: d_sel[8] = carry_input_i;
			lcs_pkg::SRC8_CARRY_OUT: d_sel[8] = carry_out_i;
			default: d_sel[8] = 1'b0;
		endcase
	end

	// The storage elements; element 8 is built flop only.
	for (genvar e = 0; e < lcs_pkg::NUM_ELEM; e++) begin : g_elem
		lcs_elem #(
			.FF_ONLY(e == 8)
		) u_elem (
			.clk_i(clk_i),
			.rst_n_i(rst_n_i),
			.en_i(run_en_i),
			.edge_i(clk_edge),
			.level_i(clk_act),
			.ff_mode_i(ff_mode),
			.d_i(d_sel[e]),
			.ce_i(ce_g[e / 4]),
			.loc_sr_i(loc_sr_g[e / 4]),
			.loc_sr_async_i(loc_sr_async),
			.loc_sr_over_ce_i(loc_sr_over_ce),
			.gsr_i(gsr_eff),
			.srval_i(r.srval[e]),
			.q_o(q_o[e])
		);
	end

	// Register writes and read data; read data stand only in the cycle after the strobe.
	always_comb begin
		r_nxt = r;
		r_nxt.clk_act_prev = clk_act;
		r_nxt.rdata = '0;
		if (cfg_wr_i) begin
			unique case (cfg_addr_i)
				lcs_pkg::OFS_CTRL: r_nxt.ctrl = cfg_wdata_i[lcs_pkg::CTRL_W-1:0];
				lcs_pkg::OFS_SRC: r_nxt.src = cfg_wdata_i[lcs_pkg::SRC_W-1:0];
				lcs_pkg::OFS_SRVAL: r_nxt.srval = cfg_wdata_i[lcs_pkg::NUM_ELEM-1:0];
				lcs_pkg::OFS_GROUP: r_nxt.grp = cfg_wdata_i[lcs_pkg::GRP_W-1:0];
				default: ;
			endcase
		end
		if (cfg_rd_i) begin
			unique case (cfg_addr_i)
				lcs_pkg::OFS_CTRL: r_nxt.rdata[lcs_pkg::CTRL_W-1:0] = r.ctrl;
				lcs_pkg::OFS_SRC: r_nxt.rdata[lcs_pkg::SRC_W-1:0] = r.src;
				lcs_pkg::OFS_SRVAL: r_nxt.rdata[lcs_pkg::NUM_ELEM-1:0] = r.srval;
				lcs_pkg::OFS_GROUP: r_nxt.rdata[lcs_pkg::GRP_W-1:0] = r.grp;
				lcs_pkg::OFS_STATUS: r_nxt.rdata[lcs_pkg::NUM_ELEM-1:0] = q_o;
				default: ;
			endcase
		end
	end

	// State register; the freeze input holds everything, the port included.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			r.ctrl <= lcs_pkg::CTRL_RST;
			r.src <= lcs_pkg::SRC_RST;
			r.srval <= lcs_pkg::SRVAL_RST;
			r.grp <= lcs_pkg::GRP_RST;
			r.clk_act_prev <= 1'b0;
			r.rdata <= '0;
		end else if (run_en_i) begin
			r <= r_nxt;
		end
	end

	assign cfg_rdata_o = r.rdata;

	// Global set/reset forces every element to its own value one cycle later.
	chk_gsr_forces_all: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		run_en_i && gsr_eff |=> q_o == $past(r.srval))
		else $error("global set/reset did not force the elements");

	// The pin acts when low; with the global path enabled, a low level forces every element.
	chk_gsr_active_low: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		run_en_i && !pins_s[1] && r.ctrl[lcs_pkg::CTRL_GSR_EN] |=> q_o == $past(r.srval))
		else $error("low global set/reset pin did not force the elements");

	// With the global path disabled, a quiet flop cell keeps its value.
	chk_gsr_ignored: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		run_en_i && !pins_s[1] && !r.ctrl[lcs_pkg::CTRL_GSR_EN] && ff_mode && !clk_edge &&
		!(loc_sr_async && |loc_sr_g) |=> $stable(q_o))
		else $error("disabled global set/reset changed an element");

	// An inactive enable holds the low group at the edge.
	chk_ce_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		run_en_i && ff_mode && clk_edge && !gsr_eff && !loc_sr_g[0] && !ce_g[0]
		|=> q_o[3:0] == $past(q_o[3:0]))
		else $error("flop changed with enable inactive");

	// The alternate enable, after the enable inversion, holds the high group when off.
	chk_alt_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		run_en_i && ff_mode && clk_edge && !gsr_eff && !loc_sr_g[1] &&
		r.grp[3:2] == lcs_pkg::CE_ALTERNATE &&
		!(alternate_clk_enable_i ^ r.ctrl[lcs_pkg::CTRL_CE_INV]) |=> $stable(q_o[7:4]))
		else $error("high group changed with its alternate enable inactive");

	// A clean edge with the enable active captures the selected data.
	chk_ff_capture: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		run_en_i && ff_mode && clk_edge && !gsr_eff && loc_sr_g == '0 && ce_g == 3'h7
		|=> q_o == $past(d_sel))
		else $error("flop did not capture its data");

	// Flops only move on a cell clock edge when nothing forces them.
	chk_flop_edge_only: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		run_en_i && ff_mode && !clk_edge && !gsr_eff && loc_sr_g == '0 |=> $stable(q_o))
		else $error("flop changed without a cell clock edge");

	// A zero source, the reset default, captures zero.
	chk_zero_source: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		run_en_i && ff_mode && !r.ctrl[lcs_pkg::CTRL_FE_MODE] && clk_edge && !gsr_eff &&
		!loc_sr_g[0] && ce_g[0] && r.src[1:0] == lcs_pkg::SRC_ZERO |=> !q_o[0])
		else $error("zero source did not capture zero");

	// A one source captures one.
	chk_one_source: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		run_en_i && ff_mode && !r.ctrl[lcs_pkg::CTRL_FE_MODE] && clk_edge && !gsr_eff &&
		!loc_sr_g[0] && ce_g[0] && r.src[1:0] == lcs_pkg::SRC_ONE |=> q_o[0])
		else $error("one source did not capture one");

	// An open latch follows its data whatever the enable says.
	chk_latch_pass: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		run_en_i && !ff_mode && clk_act && !gsr_eff && loc_sr_g[1:0] == 2'h0
		|=> q_o[7:0] == $past(d_sel[7:0]))
		else $error("open latch did not pass its data");

	// A closed latch keeps its value while its data move.
	chk_latch_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		run_en_i && !ff_mode && !clk_act && !gsr_eff && loc_sr_g[1:0] == 2'h0
		|=> q_o[7:0] == $past(q_o[7:0]))
		else $error("closed latch changed its value");

	// In latch mode the ninth element still waits for an edge.
	chk_ninth_flop: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		run_en_i && !ff_mode && clk_act && !clk_edge && !gsr_eff && !loc_sr_g[2]
		|=> q_o[8] == $past(q_o[8]))
		else $error("ninth element behaved as a latch");

	// The ninth flop takes the carry input when that source is chosen.
	chk_ninth_carry_in: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		run_en_i && clk_edge && !gsr_eff && !loc_sr_g[2] && ce_g[2] &&
		r.src[lcs_pkg::SRC_W-1 -: lcs_pkg::SRC_FIELD_W] == lcs_pkg::SRC8_CARRY_IN
		|=> q_o[8] == $past(carry_input_i))
		else $error("ninth flop missed the carry input");

	// The ninth flop takes the carry-out when that source is chosen.
	chk_ninth_carry_out: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		run_en_i && clk_edge && !gsr_eff && !loc_sr_g[2] && ce_g[2] &&
		r.src[lcs_pkg::SRC_W-1 -: lcs_pkg::SRC_FIELD_W] == lcs_pkg::SRC8_CARRY_OUT
		|=> q_o[8] == $past(carry_out_i))
		else $error("ninth flop missed the carry-out");

	// Synchronous set/reset with priority ignores an inactive enable.
	chk_sync_sr_prio: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		run_en_i && ff_mode && clk_edge && !gsr_eff && !loc_sr_async && loc_sr_over_ce &&
		loc_sr_g[0] |=> q_o[3:0] == $past(r.srval[3:0]))
		else $error("synchronous set/reset lost to the enable");

	// Without priority, synchronous set/reset waits for the enable.
	chk_sync_sr_gated: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		run_en_i && ff_mode && clk_edge && !gsr_eff && !loc_sr_async && !loc_sr_over_ce &&
		loc_sr_g[0] && !ce_g[0] |=> q_o[3:0] == $past(q_o[3:0]))
		else $error("synchronous set/reset acted with the enable inactive");

	// Asynchronous local set/reset acts without any edge.
	chk_async_sr_low: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		run_en_i && !gsr_eff && loc_sr_async && loc_sr_g[0]
		|=> q_o[3:0] == $past(r.srval[3:0]))
		else $error("asynchronous set/reset did not force the low group");

	// The asynchronous choice is cell wide, so the ninth flop follows it too.
	chk_async_sr_ninth: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		run_en_i && !gsr_eff && loc_sr_async && loc_sr_g[2]
		|=> q_o[8] == $past(r.srval[8]))
		else $error("asynchronous set/reset did not force the ninth flop");

	// Front-end mode follows the select input on captured elements 0 to 7.
	chk_front_select: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		run_en_i && ff_mode && r.ctrl[lcs_pkg::CTRL_FE_MODE] && clk_edge && !gsr_eff &&
		loc_sr_g == '0 && ce_g == 3'h7
		|=> q_o[7:0] == ($past(sel_eff) ? $past(din_i) : $past(lut_i)))
		else $error("front-end select picked the wrong input");

endmodule // lcs_cell

// ---- common/lcs_pkg.sv ----
// Constants shared by the logic cell storage stage: register map, fields and reset values.
package lcs_pkg;

	// Register byte offsets on the configuration port.
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_SRC = 8'h04;
	localparam logic [7:0] OFS_SRVAL = 8'h08;
	localparam logic [7:0] OFS_GROUP = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;

	// Cell-wide control register fields.
	localparam int CTRL_W = 9;
	localparam int CTRL_FF_MODE = 0;
	localparam int CTRL_CLK_INV = 1;
	localparam int CTRL_LOC_SR_ASYNC = 2;
	localparam int CTRL_LOC_SR_OVER_CE = 3;
	localparam int CTRL_GSR_EN = 4;
	localparam int CTRL_CE_INV = 5;
	localparam int CTRL_LOC_SR_INV = 6;
	localparam int CTRL_SEL_INV = 7;
	localparam int CTRL_FE_MODE = 8;
	localparam logic [CTRL_W-1:0] CTRL_RST = 9'h011;

	// Data source register: two bits per element, element 8 in the top pair.
	localparam int SRC_W = 18;
	localparam int SRC_FIELD_W = 2;
	localparam logic [SRC_W-1:0] SRC_RST = 18'h00000;
	localparam logic [1:0] SRC_ZERO = 2'h0;
	localparam logic [1:0] SRC_ONE = 2'h1;
	localparam logic [1:0] SRC_LUT = 2'h2;
	localparam logic [1:0] SRC_DIN = 2'h3;
	localparam logic [1:0] SRC8_CARRY_IN = 2'h2;
	localparam logic [1:0] SRC8_CARRY_OUT = 2'h3;

	// Per-element set/reset value register.
	localparam int NUM_ELEM = 9;
	localparam logic [NUM_ELEM-1:0] SRVAL_RST = 9'h000;

	// Group register: enable source per group, then local set/reset use per group.
	localparam int NUM_GRP = 3;
	localparam int GRP_W = 9;
	localparam int GRP_LOC_SR_USE = 6;
	localparam logic [GRP_W-1:0] GRP_RST = 9'h000;
	localparam logic [1:0] CE_NONE = 2'h0;
	localparam logic [1:0] CE_PRIMARY = 2'h1;
	localparam logic [1:0] CE_ALTERNATE = 2'h2;

	// Configuration port data width.
	localparam int DATA_W = 32;

endpackage

// ---- hw/lcs_sync.sv ----
// Two flip-flop synchroniser for pins that arrive from outside the clock domain.
`timescale 1ns/1ns
module lcs_sync #(
	parameter int WIDTH = 2,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	// Clock, reset and freeze.
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic en_i,
	// Asynchronous input and its synchronised copy.
	input wire logic [WIDTH-1:0] d_i,
	output logic [WIDTH-1:0] q_o
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] sync;
	} lcs_sync_state_t;

	lcs_sync_state_t s_r;
	lcs_sync_state_t s_nxt;

	// The first stage feeds only the second stage, so metastability stays contained.
	always_comb begin
		s_nxt.meta = d_i;
		s_nxt.sync = s_r.meta;
	end

	// Reset loads constants only; the pin level is caught after release.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			s_r <= {RST_VAL, RST_VAL};
		end else if (en_i) begin
			s_r <= s_nxt;
		end
	end

	assign q_o = s_r.sync;

endmodule // lcs_sync

// ---- hw/lcs_elem.sv ----
// One storage element of the cell: latch or flip-flop with set/reset forcing.
`timescale 1ns/1ns
module lcs_elem #(
	parameter bit FF_ONLY = 1'b0
) (
	// Clock, reset and freeze.
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic en_i,
	// Cell clock events, already polarity corrected.
	input wire logic edge_i,
	input wire logic level_i,
	// Mode and controls, already inverted and gated per group.
	input wire logic ff_mode_i,
	input wire logic d_i,
	input wire logic ce_i,
	input wire logic loc_sr_i,
	input wire logic loc_sr_async_i,
	input wire logic loc_sr_over_ce_i,
	input wire logic gsr_i,
	input wire logic srval_i,
	// Stored value.
	output logic q_o
);

	typedef struct packed {
		logic q;
	} lcs_elem_state_t;

	lcs_elem_state_t s_r;
	lcs_elem_state_t s_nxt;

	// Forcing wins over any capture while it stands, as a real async pin would.
	always_comb begin
		s_nxt = s_r;
		if (gsr_i || (loc_sr_i && loc_sr_async_i)) begin
			s_nxt.q = srval_i;
		end else if (ff_mode_i || FF_ONLY) begin
			// The enable is a hold mux in front of the flop.
			if (edge_i) begin
				if (loc_sr_i && (loc_sr_over_ce_i || ce_i)) begin
					s_nxt.q = srval_i;
				end else if (ce_i) begin
					s_nxt.q = d_i;
				end
			end
		end else if (level_i) begin
			// A latch is transparent while the level is active and ignores the enable.
			s_nxt.q = loc_sr_i ? srval_i : d_i;
		end
	end

	// State register.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			s_r <= '0;
		end else if (en_i) begin
			s_r <= s_nxt;
		end
	end

	assign q_o = s_r.q;

endmodule // lcs_elem

// ---- sim/lcs_env_model.sv ----
// Model of the lookup logic and carry chain that feed the storage stage.
`timescale 1ns/1ns
module lcs_env_model (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Requests from the bench.
	input wire logic fire_i,
	input wire logic slow_i,
	input wire logic hold_i,
	input wire logic [7:0] lut_set_i,
	input wire logic [7:0] din_set_i,
	input wire logic [1:0] carry_set_i,
	// Signals toward the cell.
	output logic cell_clk_o,
	output logic [7:0] lut_o,
	output logic [7:0] din_o,
	output logic carry_input_o,
	output logic carry_out_o,
	output logic busy_o
);
	logic [3:0] cnt_r;
	logic slow_r;
	// One cell clock pulse per request; a slow pulse doubles both phases.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			cnt_r <= 4'h0;
			slow_r <= 1'h0;
		end else if (cnt_r != 4'h0) begin
			cnt_r <= cnt_r - 4'h1;
		end else if (fire_i) begin
			cnt_r <= slow_i ? 4'hC : 4'h6;
			slow_r <= slow_i;
		end
	end
	// Lookup outputs settle one cycle after the operands change, like real logic.
	always_ff @(posedge clk_i) begin
		lut_o <= lut_set_i;
		din_o <= din_set_i;
		{carry_out_o, carry_input_o} <= carry_set_i;
	end
	// High phase first, then an equal low phase so the cell sees both levels.
	assign cell_clk_o = hold_i | (cnt_r > (slow_r ? 4'h6 : 4'h3));
	assign busy_o = fire_i | (cnt_r != 4'h0);
endmodule // lcs_env_model

// ---- sim/tb.sv ----
// Self-checking bench for the logic cell storage stage.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin errors++; \
	$display("unexpected %s exp=%h got=%h", nm, e, g); end end
module tb;
	logic clk_i = 1'h0;
	logic rst_n_i = 1'h0;
	logic [7:0] cfg_addr_i = 8'h00;
	logic [31:0] cfg_wdata_i = 32'h0;
	logic cfg_wr_i = 1'h0;
	logic cfg_rd_i = 1'h0;
	logic [31:0] cfg_rdata_o;
	logic fire = 1'h0;
	logic slow = 1'h0;
	logic hold = 1'h0;
	logic busy;
	logic [7:0] lut_set = 8'h00;
	logic [7:0] din_set = 8'h00;
	logic [1:0] carry_set = 2'h0;
	logic cell_clk, ci, co, cen = 1'h0, alt = 1'h0, loc_sr = 1'h0, sel = 1'h0, gsr_n = 1'h1;
	logic [7:0] lut, din;
	logic [8:0] q_o;
	int errors = 0;
	int num_checks = 0;
	logic [17:0] srcs [4] = '{18'h05555, 18'h2AAAA, 18'h3FFFF, 18'h1E4E4};

	// Free-running system clock.
	always #25 clk_i = ~clk_i;

	lcs_env_model u_env (.clk_i(clk_i), .rst_n_i(rst_n_i), .fire_i(fire), .slow_i(slow),
		.hold_i(hold), .lut_set_i(lut_set), .din_set_i(din_set), .carry_set_i(carry_set),
		.cell_clk_o(cell_clk), .lut_o(lut), .din_o(din), .carry_input_o(ci),
		.carry_out_o(co), .busy_o(busy));

	lcs_cell u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .run_en_i(1'h1),
		.cfg_addr_i(cfg_addr_i), .cfg_wdata_i(cfg_wdata_i), .cfg_wr_i(cfg_wr_i),
		.cfg_rd_i(cfg_rd_i), .cfg_rdata_o(cfg_rdata_o), .cell_clk_i(cell_clk),
		.global_set_reset_n_i(gsr_n), .lut_i(lut), .din_i(din), .carry_input_i(ci),
		.carry_out_i(co), .cell_clk_enable_i(cen), .alternate_clk_enable_i(alt),
		.local_set_reset_i(loc_sr), .data_sel_i(sel), .q_o(q_o));

	// Element values expected from the source codes and operands.
	function automatic logic [8:0] exp_q(input logic [17:0] s, input logic [7:0] l,
		input logic [7:0] d, input logic [1:0] c);
		logic [8:0] r;
		for (int i = 0; i < 9; i++) begin
			case (s[2*i +: 2])
				2'h0: r[i] = 1'h0;
				2'h1: r[i] = 1'h1;
				2'h2: r[i] = (i == 8) ? c[0] : l[i%8];
				default: r[i] = (i == 8) ? c[1] : d[i%8];
			endcase
		end
		return r;
	endfunction

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cfg_addr_i <= a;
		cfg_wdata_i <= d;
		cfg_wr_i <= 1'h1;
		@(posedge clk_i);
		cfg_wr_i <= 1'h0;
	endtask

	// Read data stand only in the cycle after the strobe, so look just past that edge.
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_i);
		cfg_addr_i <= a;
		cfg_rd_i <= 1'h1;
		@(posedge clk_i);
		cfg_rd_i <= 1'h0;
		#1;
		`CHK("cfg_rdata_o", e, cfg_rdata_o)
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	task automatic q_chk(input int n, input logic [8:0] e);
		cyc(n);
		#1;
		`CHK("q_o", e, q_o)
	endtask

	task automatic drv(input logic [7:0] l, input logic [7:0] d, input logic [1:0] c);
		@(posedge clk_i);
		lut_set <= l;
		din_set <= d;
		carry_set <= c;
	endtask

	// The pin passes two synchroniser stages, so allow settling after the pulse.
	task automatic pulse_chk(input logic s, input logic [8:0] e);
		@(posedge clk_i);
		fire <= 1'h1;
		slow <= s;
		@(posedge clk_i);
		fire <= 1'h0;
		for (int k = 0; k < 40 && busy; k++) @(posedge clk_i);
		q_chk(4, e);
	endtask

	task automatic wrap_up();
		if (errors == 0 && num_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	// A hung handshake must not stall the run.
	initial begin
		#(50 * 20000);
		errors++;
		wrap_up();
	end

	// Main test sequence.
	initial begin
		repeat (6) @(posedge clk_i);
		rst_n_i <= 1'h1;
		rd_chk(lcs_pkg::OFS_CTRL, 32'h011);
		rd_chk(lcs_pkg::OFS_SRC, 32'h0);
		rd_chk(lcs_pkg::OFS_GROUP, 32'h0);
		wr(8'h14, 32'hFFFF);
		rd_chk(8'h14, 32'h0);
		drv(8'hA5, 8'h5A, 2'h1);
		pulse_chk(1'h0, 9'h000);
		for (int k = 0; k < 4; k++) begin
			wr(lcs_pkg::OFS_SRC, {14'h0, srcs[k]});
			pulse_chk(k == 1, exp_q(srcs[k], 8'hA5, 8'h5A, 2'h1));
		end
		wr(lcs_pkg::OFS_SRC, 32'h2AAAA);
		drv(8'h00, 8'h00, 2'h0);
		pulse_chk(1'h0, 9'h000);
		wr(lcs_pkg::OFS_GROUP, 32'h19);
		alt <= 1'h1;
		rd_chk(lcs_pkg::OFS_GROUP, 32'h19);
		drv(8'hFF, 8'h00, 2'h1);
		pulse_chk(1'h0, 9'h0F0);
		wr(lcs_pkg::OFS_CTRL, 32'h031);
		drv(8'h3C, 8'h00, 2'h1);
		pulse_chk(1'h0, 9'h1FC);
		wr(lcs_pkg::OFS_CTRL, 32'h010);
		wr(lcs_pkg::OFS_GROUP, 32'h15);
		hold <= 1'h1;
		drv(8'h81, 8'h00, 2'h0);
		q_chk(6, 9'h181);
		drv(8'h42, 8'h00, 2'h0);
		q_chk(6, 9'h142);
		@(posedge clk_i);
		hold <= 1'h0;
		cyc(4);
		drv(8'h99, 8'h00, 2'h0);
		q_chk(6, 9'h142);
		wr(lcs_pkg::OFS_CTRL, 32'h011);
		wr(lcs_pkg::OFS_GROUP, 32'h0);
		drv(8'h00, 8'h00, 2'h0);
		pulse_chk(1'h0, 9'h000);
		wr(lcs_pkg::OFS_CTRL, 32'h013);
		drv(8'h11, 8'h00, 2'h0);
		hold <= 1'h1;
		q_chk(6, 9'h000);
		@(posedge clk_i);
		hold <= 1'h0;
		q_chk(6, 9'h011);
		wr(lcs_pkg::OFS_CTRL, 32'h111);
		sel <= 1'h1;
		drv(8'h0F, 8'hF0, 2'h0);
		pulse_chk(1'h0, 9'h0F0);
		@(posedge clk_i);
		sel <= 1'h0;
		pulse_chk(1'h0, 9'h00F);
		wr(lcs_pkg::OFS_CTRL, 32'h191);
		pulse_chk(1'h0, 9'h0F0);
		wr(lcs_pkg::OFS_CTRL, 32'h011);
		drv(8'h00, 8'h00, 2'h0);
		pulse_chk(1'h0, 9'h000);
		wr(lcs_pkg::OFS_SRVAL, 32'h155);
		wr(lcs_pkg::OFS_GROUP, 32'h140);
		wr(lcs_pkg::OFS_CTRL, 32'h015);
		loc_sr <= 1'h1;
		q_chk(3, 9'h105);
		drv(8'hFF, 8'h00, 2'h0);
		pulse_chk(1'h0, 9'h1F5);
		wr(lcs_pkg::OFS_CTRL, 32'h055);
		drv(8'h00, 8'h00, 2'h0);
		pulse_chk(1'h0, 9'h000);
		@(posedge clk_i);
		loc_sr <= 1'h0;
		q_chk(3, 9'h105);
		wr(lcs_pkg::OFS_CTRL, 32'h011);
		pulse_chk(1'h0, 9'h000);
		wr(lcs_pkg::OFS_GROUP, 32'h1D5);
		loc_sr <= 1'h1;
		rd_chk(lcs_pkg::OFS_GROUP, 32'h1D5);
		pulse_chk(1'h0, 9'h000);
		wr(lcs_pkg::OFS_CTRL, 32'h019);
		pulse_chk(1'h0, 9'h155);
		wr(lcs_pkg::OFS_CTRL, 32'h011);
		wr(lcs_pkg::OFS_GROUP, 32'h0);
		loc_sr <= 1'h0;
		pulse_chk(1'h0, 9'h000);
		wr(lcs_pkg::OFS_SRVAL, 32'h0AA);
		gsr_n <= 1'h0;
		q_chk(5, 9'h0AA);
		drv(8'hFF, 8'hFF, 2'h3);
		pulse_chk(1'h0, 9'h0AA);
		rd_chk(lcs_pkg::OFS_STATUS, 32'h0AA);
		@(posedge clk_i);
		gsr_n <= 1'h1;
		pulse_chk(1'h0, 9'h1FF);
		wr(lcs_pkg::OFS_CTRL, 32'h001);
		drv(8'h00, 8'h00, 2'h0);
		pulse_chk(1'h0, 9'h000);
		@(posedge clk_i);
		gsr_n <= 1'h0;
		q_chk(6, 9'h000);
		wrap_up();
	end
endmodule // tb
